// ### hdl/cmm_pkg.sv
package cmm_pkg;
  // core register offsets inside every bank
  localparam logic [6:0] OFS_IND0 = 7'h00;
  localparam logic [6:0] OFS_IND1 = 7'h01;
  localparam logic [6:0] OFS_PCLO = 7'h02;
  localparam logic [6:0] OFS_FLAGS = 7'h03;
  localparam logic [6:0] OFS_P0LO = 7'h04;
  localparam logic [6:0] OFS_P0HI = 7'h05;
  localparam logic [6:0] OFS_P1LO = 7'h06;
  localparam logic [6:0] OFS_P1HI = 7'h07;
  localparam logic [6:0] OFS_BANK = 7'h08;
  localparam logic [6:0] OFS_WACC = 7'h09;
  localparam logic [6:0] OFS_PCLH = 7'h0a;
  localparam logic [6:0] OFS_INTC = 7'h0b;
  // bank layout boundaries
  localparam logic [6:0] OFS_SFR_FIRST = 7'h0c;
  localparam logic [6:0] OFS_GPR_FIRST = 7'h20;
  localparam logic [6:0] OFS_COMMON_FIRST = 7'h70;
  localparam int GPR_PER_BANK = 80;
  localparam int COMMON_BYTES = 16;
  localparam int BANK_COUNT = 32;
  // flag register field positions
  localparam int FLG_TO_N = 4;
  localparam int FLG_PD_N = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_DC = 1;
  localparam int FLG_C = 0;
  // pointer high byte bit that selects program memory
  localparam int PTR_PM_BIT = 15;
  // vectors and reset values
  localparam logic [14:0] VEC_RESET = 15'h0000;
  localparam logic [14:0] VEC_IRQ = 15'h0004;
  localparam logic [4:0] FLAGS_POR = 5'h18;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [14:0] LAST_ADDR_SMALL = 15'h07ff;
  localparam logic [14:0] LAST_ADDR_LARGE = 15'h0fff;
  // alu operations
  typedef enum logic [1:0] {CMM_OP_ADD, CMM_OP_SUB, CMM_OP_LOGIC} cmm_op_t;
endpackage

// ### hdl/cmm_alu.sv
`timescale 1ns/1ps
`default_nettype none
module cmm_alu
  import cmm_pkg::*;
(
  input wire logic [1:0] i_op,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  output logic [7:0] o_res,
  output logic o_z,
  output logic o_dc,
  output logic o_c
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] b_eff;
  logic carry_in;

  // subtraction adds the two's complement, so carries are inverted borrows
  // carry as inverted borrow
  always_comb
  begin
    b_eff = i_b;
    carry_in = 1'b0;
    if (i_op == 2'(CMM_OP_SUB))
    begin
      b_eff = ~i_b;
      carry_in = 1'b1;
    end
    sum = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, carry_in};
    low_sum = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in};
    // logic ops pass the operand through as the result
    o_res = (i_op == 2'(CMM_OP_LOGIC)) ? i_b : sum[7:0];
    o_z = (o_res == 8'h00);
    o_dc = low_sum[4];
    o_c = sum[8];
  end
endmodule
`default_nettype wire

// ### hdl/cmm_core_regs.sv
// Notes on behaviour
// - program counter is 15 bits, space of 32K words of 14 bits
// - program addresses wrap inside 2048 or 4096 implemented words
// - fetch starts at 0000h after reset, interrupt goes to 0004h
// - pointer high bit 7 makes indirect read return program word
// - indirect move to accumulator keeps low 8 bits of word
// - indirect writes never reach program memory
// - indirect program access costs one extra cycle
// - data memory is 32 banks of 128 bytes
// - bank holds core, special, general and common areas in order
// - direct accesses use the last written bank select value
// - unimplemented data locations read zero
// - data address is 12 bits: 5 bank bits, 7 offset bits
// - twelve core registers decode at 00h..0Bh in every bank
// - instruction-updated flags override a write to flag register
// - timeout and power-down flags ignore register writes
// - flag bits 7..5 read zero
// - timeout flag set by power-up, kick, sleep; cleared by timeout
// - power-down flag set by power-up and kick; cleared by sleep
// - zero flag follows whether result is zero
// - nibble carry flag is carry out of bit 3
// - carry out of bit 7; subtract by two's complement add
// - power-on sets reset flags, clears arithmetic; warm keeps them
// - two 16-bit pointers from low and high bytes
// - special function locations sit at 0Ch..1Fh of every bank
// - common bytes map to the same storage in all banks
`timescale 1ns/1ps
`default_nettype none
module cmm_core_regs
  import cmm_pkg::*;
#(
  parameter logic [14:0] PROG_LAST = LAST_ADDR_LARGE,
  parameter int GPR_BANKS = 4
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_warm_reset,
  input wire logic i_warm_to_n,
  input wire logic i_warm_pd_n,
  input wire logic i_pc_advance,
  input wire logic i_pc_jump,
  input wire logic [14:0] i_pc_target,
  input wire logic i_irq_take,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic i_req_linear,
  input wire logic [11:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  input wire logic i_alu_en,
  input wire logic [1:0] i_alu_op,
  input wire logic [7:0] i_alu_a,
  input wire logic [7:0] i_alu_b,
  input wire logic [2:0] i_flag_mask,
  input wire logic i_wdt_kick,
  input wire logic i_sleep,
  input wire logic i_wdt_timeout,
  input wire logic [13:0] i_pm_data,
  input wire logic [7:0] i_sfr_rdata,
  output logic [14:0] o_prog_addr,
  output logic [14:0] o_pm_addr,
  output logic o_pm_rd,
  output logic o_busy,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic [7:0] o_alu_res,
  output logic o_sfr_sel,
  output logic o_sfr_write,
  output logic [11:0] o_sfr_addr,
  output logic [7:0] o_sfr_wdata,
  output logic [7:0] o_flags,
  output logic [7:0] o_wacc,
  output logic [4:0] o_bank,
  output logic [7:0] o_intctl
);
  localparam int GPR_TOTAL = GPR_BANKS * GPR_PER_BANK;
  localparam int GIW = $clog2(GPR_TOTAL);

  logic [14:0] pc_reg, pc_next;
  logic [7:0] pc_latch_hi_reg, alu_res, rd_mux;
  logic [15:0] ptr0_reg, ptr1_reg, sel_ptr;
  logic [4:0] flags_reg, flags_next, eff_bank;
  logic busy_reg, alu_z, alu_dc, alu_c, is_ind, ind_pm, gpr_hit;
  logic go, wr_core, wr_data;
  logic [7:0] gpr_mem [GPR_TOTAL];
  logic [7:0] common_mem [COMMON_BYTES];
  logic [11:0] eff_addr;
  logic [6:0] eff_ofs;
  logic [GIW-1:0] gpr_idx;
  logic [3:0] com_idx;

  cmm_alu u_alu
  (
    .i_op(i_alu_op),
    .i_a(i_alu_a),
    .i_b(i_alu_b),
    .o_res(alu_res),
    .o_z(alu_z),
    .o_dc(alu_dc),
    .o_c(alu_c)
  );

  // requests are refused while a program word fetch is pending
  assign go = i_clk_en & i_req_valid & ~busy_reg;

  // address resolution for direct and indirect access
  always_comb
  begin
    sel_ptr = (i_req_addr[6:0] == OFS_IND1) ? ptr1_reg : ptr0_reg;
    is_ind = ~i_req_linear &
      ((i_req_addr[6:0] == OFS_IND0) | (i_req_addr[6:0] == OFS_IND1));
    ind_pm = is_ind & sel_ptr[PTR_PM_BIT];
    if (i_req_linear)
      eff_addr = i_req_addr;
    else if (is_ind)
      eff_addr = sel_ptr[11:0];
    else
      eff_addr = {o_bank, i_req_addr[6:0]};
    eff_bank = eff_addr[11:7];
    eff_ofs = eff_addr[6:0];
    com_idx = eff_ofs[3:0];
    gpr_hit = (eff_ofs >= OFS_GPR_FIRST) & (eff_ofs < OFS_COMMON_FIRST) &
      (32'(eff_bank) < GPR_BANKS);
    gpr_idx = GIW'(32'(eff_bank) * GPR_PER_BANK +
      32'(eff_ofs - OFS_GPR_FIRST));
  end

  // write strobes; writes through a port aimed at program memory drop
  // no program memory write
  assign wr_core = go & i_req_write & ~ind_pm & (eff_ofs < OFS_SFR_FIRST);
  assign wr_data = go & i_req_write & ~ind_pm;

  // read data mux over the bank layout
  // bank layout decode
  always_comb
  begin
    rd_mux = 8'h00;
    if (eff_ofs < OFS_SFR_FIRST)
    begin
      case (eff_ofs)
        OFS_PCLO: rd_mux = pc_reg[7:0];
        OFS_FLAGS: rd_mux = {3'h0, flags_reg};
        OFS_P0LO: rd_mux = ptr0_reg[7:0];
        OFS_P0HI: rd_mux = ptr0_reg[15:8];
        OFS_P1LO: rd_mux = ptr1_reg[7:0];
        OFS_P1HI: rd_mux = ptr1_reg[15:8];
        OFS_BANK: rd_mux = {3'h0, o_bank};
        OFS_WACC: rd_mux = o_wacc;
        OFS_PCLH: rd_mux = pc_latch_hi_reg;
        OFS_INTC: rd_mux = o_intctl;
        // nested indirect port access reads zero
        default: rd_mux = 8'h00;
      endcase
    end
    else if (eff_ofs < OFS_GPR_FIRST)
      rd_mux = i_sfr_rdata;
    else if (eff_ofs >= OFS_COMMON_FIRST)
      rd_mux = common_mem[com_idx];
    else if (gpr_hit)
      rd_mux = gpr_mem[gpr_idx];
    else
      rd_mux = 8'h00;
  end

  // program counter: reset vector, interrupt vector, jumps, low-byte writes
  always_comb
  begin
    pc_next = pc_reg;
    if (i_warm_reset)
      pc_next = VEC_RESET;
    else if (i_irq_take)
      pc_next = VEC_IRQ;
    else if (wr_core & (eff_ofs == OFS_PCLO))
      pc_next = {pc_latch_hi_reg[6:0], i_req_wdata};
    else if (i_pc_jump)
      pc_next = i_pc_target;
    else if (i_pc_advance)
      pc_next = pc_reg + 15'h0001;
    pc_next = pc_next & PROG_LAST;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      pc_reg <= VEC_RESET;
    else if (i_clk_en)
      pc_reg <= pc_next;
  end

  // core byte registers
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      pc_latch_hi_reg <= BYTE_RESET;
      ptr0_reg <= 16'h0000;
      ptr1_reg <= 16'h0000;
      o_bank <= 5'h00;
      o_wacc <= BYTE_RESET;
      o_intctl <= BYTE_RESET;
    end
    else if (wr_core)
    begin
      case (eff_ofs)
        OFS_P0LO: ptr0_reg[7:0] <= i_req_wdata;
        OFS_P0HI: ptr0_reg[15:8] <= i_req_wdata;
        OFS_P1LO: ptr1_reg[7:0] <= i_req_wdata;
        OFS_P1HI: ptr1_reg[15:8] <= i_req_wdata;
        // only five bank bits exist
        // thirty-two banks
        OFS_BANK: o_bank <= i_req_wdata[4:0];
        OFS_WACC: o_wacc <= i_req_wdata;
        OFS_PCLH: pc_latch_hi_reg <= i_req_wdata;
        OFS_INTC: o_intctl <= i_req_wdata;
        default: pc_latch_hi_reg <= pc_latch_hi_reg;
      endcase
    end
  end

  // flag register next value
  always_comb
  begin
    flags_next = flags_reg;
    if (wr_core & (eff_ofs == OFS_FLAGS))
      flags_next[FLG_Z:FLG_C] = i_req_wdata[FLG_Z:FLG_C];
    // alu update lands after the write, so its bits win
    // instruction flags override write
    if (i_clk_en & i_alu_en)
    begin
      if (i_flag_mask[FLG_Z])
        flags_next[FLG_Z] = alu_z;
      if (i_flag_mask[FLG_DC])
        flags_next[FLG_DC] = alu_dc;
      if (i_flag_mask[FLG_C])
        flags_next[FLG_C] = alu_c;
    end
    // kick wins over sleep when both arrive together
    // timeout flag events
    if (i_wdt_kick | i_sleep)
      flags_next[FLG_TO_N:FLG_PD_N] = {1'b1, i_wdt_kick};
    if (i_wdt_timeout)
      flags_next[FLG_TO_N] = 1'b0;
    // warm reset keeps arithmetic flags, loads the reset flags
    if (i_warm_reset)
      flags_next[FLG_TO_N:FLG_PD_N] = {i_warm_to_n, i_warm_pd_n};
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      flags_reg <= FLAGS_POR;
    else if (i_clk_en)
      flags_reg <= flags_next;
  end

  // data storage; the array is not reset, as a RAM would not be
  always_ff @(posedge i_clock)
  begin
    if (wr_data & (eff_ofs >= OFS_COMMON_FIRST))
      common_mem[com_idx] <= i_req_wdata;
    else if (wr_data & gpr_hit)
      gpr_mem[gpr_idx] <= i_req_wdata;
  end

  // program word fetch through a pointer
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      busy_reg <= 1'b0;
      o_pm_addr <= 15'h0000;
    end
    else if (i_clk_en)
    begin
      // one extra cycle; go is low while busy, so it drops
      busy_reg <= go & ~i_req_write & ind_pm;
      if (go & ~i_req_write & ind_pm)
        o_pm_addr <= sel_ptr[14:0] & PROG_LAST;
    end
  end

  // read answer; program words give their low byte
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_rd_valid <= busy_reg | (go & ~i_req_write & ~ind_pm);
      if (busy_reg)
        o_rd_data <= i_pm_data[7:0];
      else if (go & ~i_req_write & ~ind_pm)
        o_rd_data <= rd_mux;
    end
  end

  // special function strobes, registered toward the peripherals
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sfr_sel <= 1'b0;
      o_sfr_write <= 1'b0;
      o_sfr_addr <= 12'h000;
      o_sfr_wdata <= 8'h00;
    end
    else if (i_clk_en)
    begin
      o_sfr_sel <= go & ~ind_pm & (eff_ofs >= OFS_SFR_FIRST) &
        (eff_ofs < OFS_GPR_FIRST);
      o_sfr_write <= wr_data & (eff_ofs >= OFS_SFR_FIRST) &
        (eff_ofs < OFS_GPR_FIRST);
      o_sfr_addr <= eff_addr;
      o_sfr_wdata <= i_req_wdata;
    end
  end

  // mirrored views, one flop each behind the outputs
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_prog_addr <= VEC_RESET;
      o_pm_rd <= 1'b0;
      o_busy <= 1'b0;
      o_flags <= {3'h0, FLAGS_POR};
      o_alu_res <= 8'h00;
    end
    else if (i_clk_en)
    begin
      o_prog_addr <= pc_next;
      o_pm_rd <= go & ~i_req_write & ind_pm;
      o_busy <= go & ~i_req_write & ind_pm;
      o_flags <= {3'h0, flags_next};
      // alu result only moves on an alu step
      if (i_alu_en)
        o_alu_res <= alu_res;
    end
  end
endmodule
`default_nettype wire

// ### test/cmm_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module cmm_far_side
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_pm_rd,
  input wire logic [14:0] i_pm_addr,
  input wire logic [11:0] i_req_addr,
  output logic [13:0] o_pm_data,
  output logic [7:0] o_sfr_rdata
);
  logic [13:0] junk_reg;
  // idle bus toggles so a stale word never passes for a good one
  always_ff @(posedge i_clock or posedge i_rst)
    if (i_rst)
      junk_reg <= 14'h0000;
    else
      junk_reg <= ~junk_reg;
  // program word stands only while the read strobe is up
  assign o_pm_data = i_pm_rd ? (i_pm_addr[13:0] ^ 14'h2a5a) : junk_reg;
  // peripherals answer with their own offset, top bit set
  assign o_sfr_rdata = {1'h1, i_req_addr[6:0]};
endmodule
`default_nettype wire

// ### test/cmm_core_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module cmm_core_regs_props
  import cmm_pkg::*;
#(
  parameter logic [14:0] PROG_LAST = LAST_ADDR_LARGE
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_warm_reset,
  input wire logic i_irq_take,
  input wire logic i_pc_jump,
  input wire logic i_alu_en,
  input wire logic [2:0] i_flag_mask,
  input wire logic i_wdt_kick,
  input wire logic i_sleep,
  input wire logic i_wdt_timeout,
  input wire logic [13:0] i_pm_data,
  input wire logic [14:0] o_prog_addr,
  input wire logic o_pm_rd,
  input wire logic o_busy,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire logic [7:0] o_alu_res,
  input wire logic [7:0] o_flags
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  property p_wrap; o_prog_addr <= PROG_LAST; endproperty
  a_wrap: assert property (p_wrap) else $error("pc beyond memory");
  property p_busy; o_pm_rd |-> o_busy && !o_rd_valid; endproperty
  a_busy: assert property (p_busy) else $error("no stall");
  property p_pm_data;
    o_pm_rd |=> o_rd_valid && o_rd_data == $past(i_pm_data[7:0]);
  endproperty
  a_pm_data: assert property (p_pm_data) else $error("bad word");
  property p_hi; o_flags[7:5] == 3'h0; endproperty
  a_hi: assert property (p_hi) else $error("flag top set");
  property p_warm; i_warm_reset && i_clk_en |=> o_prog_addr == VEC_RESET;
  endproperty
  a_warm: assert property (p_warm) else $error("bad reset pc");
  property p_irq;
    i_irq_take && i_clk_en && !i_warm_reset && !i_pc_jump
      |=> o_prog_addr == VEC_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("bad irq pc");
  property p_tmo; i_wdt_timeout && i_clk_en && !i_warm_reset |=> !o_flags[4];
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout kept");
  property p_sleep;
    i_sleep && i_clk_en && !(i_wdt_timeout || i_wdt_kick || i_warm_reset)
      |=> o_flags[4:3] == 2'h2;
  endproperty
  a_sleep: assert property (p_sleep) else $error("bad sleep");
  property p_kick;
    i_wdt_kick && i_clk_en && !(i_wdt_timeout || i_sleep || i_warm_reset)
      |=> o_flags[4:3] == 2'h3;
  endproperty
  a_kick: assert property (p_kick) else $error("bad kick");
  property p_zero;
    i_alu_en && i_clk_en && i_flag_mask[2] && !i_warm_reset
      |=> o_flags[2] == (o_alu_res == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("bad zero");
  // main scenarios seen
  c_pm: cover property (o_pm_rd);
  c_sleep: cover property (i_sleep);
  c_warm: cover property (i_warm_reset);
endmodule
bind cmm_core_regs cmm_core_regs_props #(.PROG_LAST(PROG_LAST))
  i_cmm_core_regs_props (.i_clock, .i_rst, .i_clk_en, .i_warm_reset,
  .i_irq_take, .i_pc_jump, .i_alu_en, .i_flag_mask, .i_wdt_kick, .i_sleep,
  .i_wdt_timeout, .i_pm_data, .o_prog_addr, .o_pm_rd, .o_busy, .o_rd_data,
  .o_rd_valid, .o_alu_res, .o_flags);
`default_nettype wire

// ### test/core_memory_map_and_alu_flags_test.sv
`timescale 1ns/1ps
`default_nettype none
module core_memory_map_and_alu_flags_test;
  import cmm_pkg::*;
  logic i_clock = 1'h0, i_rst = 1'h1, i_clk_en = 1'h1, i_warm_reset = 1'h0;
  logic i_warm_to_n = 1'h1, i_warm_pd_n = 1'h1, i_pc_advance = 1'h0;
  logic i_pc_jump = 1'h0, i_irq_take = 1'h0, i_req_valid = 1'h0;
  logic i_req_write = 1'h0, i_req_linear = 1'h0, i_alu_en = 1'h0;
  logic i_wdt_kick = 1'h0, i_sleep = 1'h0, i_wdt_timeout = 1'h0;
  logic [14:0] i_pc_target = 15'h0000, o_prog_addr, o_pm_addr;
  logic [11:0] i_req_addr = 12'h000, o_sfr_addr;
  logic [7:0] i_req_wdata = 8'h00, i_alu_a = 8'h00, i_alu_b = 8'h00;
  logic [1:0] i_alu_op = 2'h0;
  logic [2:0] i_flag_mask = 3'h0;
  logic [13:0] i_pm_data;
  logic [7:0] i_sfr_rdata, o_rd_data, o_alu_res, o_sfr_wdata, o_flags;
  logic [7:0] o_wacc, o_intctl;
  logic o_pm_rd, o_busy, o_rd_valid, o_sfr_sel, o_sfr_write;
  logic [4:0] o_bank;
  logic [8:0] s;
  logic [4:0] d;
  int failures = 0, total_checks = 0, k;
  // design under test, default memory size
  cmm_core_regs i_cmm_core_regs (.i_clock, .i_rst, .i_clk_en, .i_warm_reset,
    .i_warm_to_n, .i_warm_pd_n, .i_pc_advance, .i_pc_jump, .i_pc_target,
    .i_irq_take, .i_req_valid, .i_req_write, .i_req_linear, .i_req_addr,
    .i_req_wdata, .i_alu_en, .i_alu_op, .i_alu_a, .i_alu_b, .i_flag_mask,
    .i_wdt_kick, .i_sleep, .i_wdt_timeout, .i_pm_data, .i_sfr_rdata,
    .o_prog_addr, .o_pm_addr, .o_pm_rd, .o_busy, .o_rd_data, .o_rd_valid,
    .o_alu_res, .o_sfr_sel, .o_sfr_write, .o_sfr_addr, .o_sfr_wdata,
    .o_flags, .o_wacc, .o_bank, .o_intctl);
  // program memory and peripherals on the far side
  cmm_far_side i_cmm_far_side (.i_clock(i_clock), .i_rst(i_rst),
    .i_pm_rd(o_pm_rd), .i_pm_addr(o_pm_addr), .i_req_addr(i_req_addr),
    .o_pm_data(i_pm_data), .o_sfr_rdata(i_sfr_rdata));
  // 10 MHz clock
  always #50 i_clock = ~i_clock;
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // inputs move 1 ns after the edge, never on it
  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask
  task automatic req(input logic [11:0] a, input logic [7:0] v,
    input logic w, input logic lin);
    tick;
    i_req_valid = 1'h1;
    i_req_write = w;
    i_req_linear = lin;
    i_req_addr = a;
    i_req_wdata = v;
    tick;
    i_req_valid = 1'h0;
  endtask
  // read with a bounded wait for the answer
  task automatic rc(input logic [11:0] a, input logic lin, input logic [7:0] e);
    int n;
    req(a, 8'h00, 1'h0, lin);
    n = 0;
    while (o_rd_valid !== 1'h1 && n < 4)
    begin
      tick;
      n++;
    end
    if (n == 4)
    begin
      failures++;
      report_and_stop;
    end
    chk(o_rd_data, e);
  endtask
  task automatic pulse(ref logic sig);
    tick;
    sig = 1'h1;
    tick;
    sig = 1'h0;
  endtask
  // alu step, optionally racing a flag register write
  task automatic alu(input logic [1:0] op, input logic [7:0] a, b,
    input logic wf);
    tick;
    i_alu_en = 1'h1;
    i_alu_op = op;
    i_alu_a = a;
    i_alu_b = b;
    i_flag_mask = 3'h7;
    i_req_valid = wf;
    i_req_write = 1'h1;
    i_req_addr = 12'h003;
    i_req_wdata = 8'h00;
    tick;
    i_alu_en = 1'h0;
    i_req_valid = 1'h0;
    s = {1'h0, a} + (op == 2'h1 ? 9'h100 - b : {1'h0, b});
    d = {1'h0, a[3:0]} + (op == 2'h1 ? 5'h10 - b[3:0] : {1'h0, b[3:0]});
    // pass operation hands b through, carries still from the adder
    if (op == 2'h2)
      s[7:0] = b;
    chk(o_alu_res, s[7:0]);
    chk(o_flags[2:0], {s[7:0] == 8'h00, d[4], s[8]});
  endtask
  initial
  begin
    repeat (10) @(posedge i_clock);
    #1;
    i_rst = 1'h0;
    chk(o_flags, 8'h18);
    chk(o_prog_addr, VEC_RESET);
    // core registers seen from a far bank
    for (k = 4; k < 12; k++)
      req(12'(k), 8'h30 + 8'(k), 1'h1, 1'h0);
    for (k = 4; k < 12; k++)
      rc(12'h780 + 12'(k), 1'h0, k == 8 ? 8'h18 : 8'h30 + 8'(k));
    chk({o_bank, o_wacc, o_intctl}, {5'h18, 8'h39, 8'h3b});
    // read-only reset flags survive writes
    req(12'h003, 8'hff, 1'h1, 1'h0);
    rc(12'h003, 1'h0, 8'h1f);
    req(12'h003, 8'h00, 1'h1, 1'h0);
    rc(12'h003, 1'h0, 8'h18);
    pulse(i_sleep);
    chk(o_flags[4:3], 2'h2);
    pulse(i_wdt_timeout);
    chk(o_flags[4:3], 2'h0);
    pulse(i_wdt_kick);
    chk(o_flags[4:3], 2'h3);
    // a frozen clock enable ignores a sleep pulse
    i_clk_en = 1'h0;
    pulse(i_sleep);
    chk(o_flags[4:3], 2'h3);
    i_clk_en = 1'h1;
    // warm reset keeps arithmetic flags
    req(12'h003, 8'h05, 1'h1, 1'h0);
    i_warm_to_n = 1'h0;
    pulse(i_warm_reset);
    chk(o_flags, 8'h0d);
    i_warm_to_n = 1'h1;
    alu(2'h0, 8'h0f, 8'h01, 1'h0);
    alu(2'h0, 8'hff, 8'h01, 1'h1);
    alu(2'h1, 8'h05, 8'h05, 1'h0);
    alu(2'h1, 8'h00, 8'h01, 1'h0);
    alu(2'h2, 8'h0f, 8'h00, 1'h0);
    // banked, linear and common memory
    req(12'h008, 8'h01, 1'h1, 1'h0);
    req(12'h020, 8'ha1, 1'h1, 1'h0);
    req(12'h070, 8'hc3, 1'h1, 1'h0);
    req(12'h008, 8'h00, 1'h1, 1'h0);
    req(12'h020, 8'hb0, 1'h1, 1'h0);
    rc(12'h0a0, 1'h1, 8'ha1);
    req(12'h008, 8'h03, 1'h1, 1'h0);
    rc(12'h070, 1'h0, 8'hc3);
    rc(12'h020, 1'h1, 8'hb0);
    req(12'h008, 8'h05, 1'h1, 1'h0);
    req(12'h020, 8'h77, 1'h1, 1'h0);
    rc(12'h020, 1'h0, 8'h00);
    rc(12'h00c, 1'h0, 8'h8c);
    chk(o_sfr_sel, 1'h1);
    req(12'h01f, 8'h5e, 1'h1, 1'h0);
    chk({o_sfr_write, o_sfr_addr, o_sfr_wdata}, {1'h1, 12'h29f, 8'h5e});
    // program word through pointer 1, then a dropped write
    req(12'h123, 8'h42, 1'h1, 1'h1);
    req(12'h006, 8'h23, 1'h1, 1'h0);
    req(12'h007, 8'h81, 1'h1, 1'h0);
    req(12'h001, 8'h00, 1'h0, 1'h0);
    chk({o_pm_rd, o_busy, o_pm_addr}, {2'h3, 15'h0123});
    tick;
    chk({o_rd_valid, o_rd_data}, {1'h1, 8'h79});
    req(12'h001, 8'h99, 1'h1, 1'h0);
    chk({o_sfr_write, o_pm_rd}, 2'h0);
    rc(12'h123, 1'h1, 8'h42);
    // counter wrap and vectors
    req(12'h00a, 8'h0f, 1'h1, 1'h0);
    req(12'h002, 8'hff, 1'h1, 1'h0);
    chk(o_prog_addr, 15'h0fff);
    pulse(i_pc_advance);
    chk(o_prog_addr, 15'h0000);
    i_pc_target = 15'h1005;
    pulse(i_pc_jump);
    chk(o_prog_addr, 15'h0005);
    pulse(i_irq_take);
    chk(o_prog_addr, VEC_IRQ);
    report_and_stop;
  end
endmodule
`default_nettype wire
